/* core/dc_flags_defines.svh */
// offsets, field positions and reset values for the chain port error flags
`ifndef DC_FLAGS_DEFINES_SVH
`define DC_FLAGS_DEFINES_SVH

`define ADDR_W         12
`define DATA_W         8

`define OFF_BIT_DIAG   12'h783
`define OFF_CMD_STAT   12'h784
`define OFF_RESP_STAT  12'h785
`define OFF_CTRL       12'h7a0
`define OFF_INT_STAT   12'h7a1
`define OFF_INT_CLR    12'h7a2
`define OFF_INT_EN     12'h7a3

`define BIT_CRC        0
`define BIT_UNEXP      1
`define BIT_BYTE       2
`define BIT_SOF        3
`define BIT_INIT       5
`define DIAG_SUM       4
`define DIAG_W         4

`define CTRL_DIR       0
`define CTRL_CLR       1

`define INT_CMD        0
`define INT_RESP       1
`define INT_DIAG       2
`define INT_W          3

`define RST_BYTE       8'h00
`define RST_INT        3'h0

`endif

/* core/dc_flags_pkg.sv */
// types shared by the chain port error flag logic
package dc_flags_pkg;

    typedef enum logic [1:0] {
        FS_IDLE,
        FS_CMD,
        FS_RESP,
        FS_SKIP
    } frame_state_t;

endpackage

/* core/dc_frame_error_flags.sv */
// error detection and status flags for frames on the high side chain port
`timescale 1ns/1ps
`default_nettype none
`include "dc_flags_defines.svh"

module dc_frame_error_flags (
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic [`ADDR_W-1:0] i_addr,
    input  wire logic [`DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output logic      [`DATA_W-1:0] o_rd_data,
    input  wire logic              i_rx_byte,
    input  wire logic              i_rx_sof,
    input  wire logic              i_rx_resp,
    input  wire logic              i_rx_init_err,
    input  wire logic              i_rx_byte_err,
    input  wire logic              i_frame_end,
    input  wire logic              i_crc_ok,
    input  wire logic [`DIAG_W-1:0] i_bit_diag,
    output logic                   o_irq,
    output logic                   o_dir_sel
);

    function automatic logic hit(input logic [`ADDR_W-1:0] a,
                                 input logic [`ADDR_W-1:0] off);
        return a == off;
    endfunction

    dc_flags_pkg::frame_state_t state_q;
    dc_flags_pkg::frame_state_t state_d;

    logic [`DATA_W-1:0] cmd_set;
    logic [`DATA_W-1:0] resp_set;
    logic [`DATA_W-1:0] diag_set;
    logic [`DATA_W-1:0] flag_clr;
    logic [`DATA_W-1:0] cmd_q;
    logic [`DATA_W-1:0] resp_q;
    logic [`DATA_W-1:0] diag_q;
    logic [`DATA_W-1:0] rd_d;
    logic [`DATA_W-1:0] rd_q;
    logic [`INT_W-1:0]  int_set;
    logic [`INT_W-1:0]  int_clr;
    logic [`INT_W-1:0]  int_q;
    logic [`INT_W-1:0]  int_en_q;
    logic               dir_q;
    logic               irq_q;
    logic               clr_req;
    logic               bad_byte;

    assign o_rd_data = rd_q;
    assign o_irq     = irq_q;
    assign o_dir_sel = dir_q;

    // a start marker or a decode fault on a mid-frame byte
    assign bad_byte = i_rx_byte && (i_rx_sof || i_rx_byte_err);

    // frame tracker: one pass per frame, errors end checking until frame end
    always_comb begin
        state_d  = state_q;
        cmd_set  = `RST_BYTE;
        resp_set = `RST_BYTE;
        case (state_q)
            dc_flags_pkg::FS_IDLE: begin
                if (i_rx_byte) begin
                    if (i_rx_init_err || !i_rx_sof) begin
                        cmd_set[`BIT_INIT] = dir_q;
                        state_d = i_frame_end ? dc_flags_pkg::FS_IDLE : dc_flags_pkg::FS_SKIP;
                    end else if (i_rx_resp) begin
                        if (dir_q) begin
                            resp_set[`BIT_UNEXP] = 1'b1;
                            state_d = dc_flags_pkg::FS_SKIP;
                        end else begin
                            state_d = dc_flags_pkg::FS_RESP;
                        end
                    end else begin
                        if (!dir_q) begin
                            cmd_set[`BIT_UNEXP] = 1'b1;
                            state_d = dc_flags_pkg::FS_SKIP;
                        end else begin
                            state_d = dc_flags_pkg::FS_CMD;
                        end
                    end
                end
            end
            dc_flags_pkg::FS_CMD: begin
                if (bad_byte) begin
                    // start marker outranks a byte fault on the same byte
                    cmd_set[`BIT_SOF]  = i_rx_sof && dir_q;
                    cmd_set[`BIT_BYTE] = !i_rx_sof && dir_q;
                    state_d = i_frame_end ? dc_flags_pkg::FS_IDLE : dc_flags_pkg::FS_SKIP;
                end else if (i_frame_end) begin
                    // a dropped frame reports the checksum only
                    cmd_set[`BIT_CRC] = !i_crc_ok;
                    state_d = dc_flags_pkg::FS_IDLE;
                end
            end
            dc_flags_pkg::FS_RESP: begin
                if (bad_byte) begin
                    resp_set[`BIT_SOF]  = i_rx_sof && !dir_q;
                    resp_set[`BIT_BYTE] = !i_rx_sof && !dir_q;
                    state_d = i_frame_end ? dc_flags_pkg::FS_IDLE : dc_flags_pkg::FS_SKIP;
                end else if (i_frame_end) begin
                    resp_set[`BIT_CRC] = !i_crc_ok;
                    state_d = dc_flags_pkg::FS_IDLE;
                end
            end
            dc_flags_pkg::FS_SKIP: begin
                // nothing is checked until the frame is over
                if (i_frame_end) begin
                    state_d = dc_flags_pkg::FS_IDLE;
                end
            end
            default: begin
                state_d = dc_flags_pkg::FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= dc_flags_pkg::FS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // byte faults also mark the bit diagnostic summary
    always_comb begin
        diag_set = `RST_BYTE;
        diag_set[`DIAG_W-1:0] = i_bit_diag;
        diag_set[`DIAG_SUM]   = (|i_bit_diag) || cmd_set[`BIT_BYTE] || resp_set[`BIT_BYTE];
    end

    // one write clears all error flags; an error in that cycle still lands
    assign clr_req  = i_wr_en && hit(i_addr, `OFF_CTRL) && i_wr_data[`CTRL_CLR];
    assign flag_clr = {`DATA_W{clr_req}};

    dc_sticky_bits #(
        .W (`DATA_W)
    ) u_cmd_flags (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_set    (cmd_set),
        .i_clr    (flag_clr),
        .o_bits   (cmd_q)
    );

    dc_sticky_bits #(
        .W (`DATA_W)
    ) u_resp_flags (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_set    (resp_set),
        .i_clr    (flag_clr),
        .o_bits   (resp_q)
    );

    dc_sticky_bits #(
        .W (`DATA_W)
    ) u_diag_flags (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_set    (diag_set),
        .i_clr    (flag_clr),
        .o_bits   (diag_q)
    );

    assign int_set[`INT_CMD]  = |cmd_set;
    assign int_set[`INT_RESP] = |resp_set;
    assign int_set[`INT_DIAG] = |diag_set;
    assign int_clr = (i_wr_en && hit(i_addr, `OFF_INT_CLR)) ? i_wr_data[`INT_W-1:0] : `RST_INT;

    dc_sticky_bits #(
        .W (`INT_W)
    ) u_int_flags (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_set    (int_set),
        .i_clr    (int_clr),
        .o_bits   (int_q)
    );

    // status registers ignore writes at their own offsets; only the clear writes reset them
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            dir_q <= 1'b0;
        end else if (i_wr_en && hit(i_addr, `OFF_CTRL)) begin
            dir_q <= i_wr_data[`CTRL_DIR];
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            int_en_q <= `RST_INT;
        end else if (i_wr_en && hit(i_addr, `OFF_INT_EN)) begin
            int_en_q <= i_wr_data[`INT_W-1:0];
        end
    end

    // registered, so the line trails its status bit by one cycle
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_q & int_en_q);
        end
    end

    always_comb begin
        rd_d = `RST_BYTE;
        if (hit(i_addr, `OFF_BIT_DIAG)) begin
            rd_d = diag_q;
        end else if (hit(i_addr, `OFF_CMD_STAT)) begin
            rd_d = cmd_q;
        end else if (hit(i_addr, `OFF_RESP_STAT)) begin
            rd_d = resp_q;
        end else if (hit(i_addr, `OFF_CTRL)) begin
            rd_d[`CTRL_DIR] = dir_q;
        end else if (hit(i_addr, `OFF_INT_STAT)) begin
            rd_d[`INT_W-1:0] = int_q;
        end else if (hit(i_addr, `OFF_INT_EN)) begin
            rd_d[`INT_W-1:0] = int_en_q;
        end
    end

    // data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_q <= `RST_BYTE;
        end else begin
            rd_q <= i_rd_en ? rd_d : `RST_BYTE;
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);

    a_cmd_sof_flag: assert property (
        state_q == dc_flags_pkg::FS_CMD && i_rx_byte && i_rx_sof && dir_q |=> cmd_q[`BIT_SOF])
        else $error("command start error not flagged");

    a_sof_mid_frame: assert property (
        state_q == dc_flags_pkg::FS_RESP && i_rx_byte && i_rx_sof && !dir_q
        |=> resp_q[`BIT_SOF] ##1 resp_q[`BIT_SOF] || $past(clr_req))
        else $error("response start error not flagged");

    a_cmd_byte_flag: assert property (
        state_q == dc_flags_pkg::FS_CMD && i_rx_byte && !i_rx_sof && i_rx_byte_err && dir_q
        |=> cmd_q[`BIT_BYTE] && !cmd_q[`BIT_SOF] || $past(cmd_q[`BIT_SOF]))
        else $error("command byte fault not flagged");

    a_diag_summary: assert property (
        cmd_set[`BIT_BYTE] |=> diag_q[`DIAG_SUM] && int_q[`INT_DIAG])
        else $error("byte fault missing from diagnostic summary");

    a_cmd_unexp: assert property (
        state_q == dc_flags_pkg::FS_IDLE && i_rx_byte && i_rx_sof && !i_rx_init_err
        && !i_rx_resp && !dir_q |=> cmd_q[`BIT_UNEXP] && state_q == dc_flags_pkg::FS_SKIP)
        else $error("command from wrong direction not flagged");

    a_cmd_crc: assert property (
        state_q == dc_flags_pkg::FS_CMD && !bad_byte && i_frame_end && !i_crc_ok
        |=> cmd_q[`BIT_CRC] && state_q == dc_flags_pkg::FS_IDLE)
        else $error("command checksum fault not flagged");

    a_crc_alone: assert property (
        state_q == dc_flags_pkg::FS_CMD && !bad_byte && i_frame_end && !i_crc_ok && !clr_req
        |=> cmd_q[`BIT_SOF:`BIT_UNEXP] == $past(cmd_q[`BIT_SOF:`BIT_UNEXP]))
        else $error("dropped frame reported other errors");

    a_resp_unexp: assert property (
        state_q == dc_flags_pkg::FS_IDLE && i_rx_byte && i_rx_sof && !i_rx_init_err
        && i_rx_resp && dir_q |=> resp_q[`BIT_UNEXP] ##1 int_q[`INT_RESP] || $past(int_clr[`INT_RESP]))
        else $error("response from wrong direction not flagged");

    a_clear_zero: assert property (
        clr_req && cmd_set == `RST_BYTE |=> cmd_q == `RST_BYTE)
        else $error("command flags not zero after clear");

    a_skip_quiet: assert property (
        state_q == dc_flags_pkg::FS_SKIP |-> cmd_set == `RST_BYTE && resp_set == `RST_BYTE)
        else $error("error checked in a skipped frame");

    a_ro_status: assert property (
        i_wr_en && hit(i_addr, `OFF_RESP_STAT) && resp_set == `RST_BYTE && !clr_req
        |=> $stable(resp_q))
        else $error("write changed a read-only status register");

    a_resp_crc: assert property (
        state_q == dc_flags_pkg::FS_RESP && !bad_byte && i_frame_end && !i_crc_ok
        |=> resp_q[`BIT_CRC] ##1 (irq_q || !$past(int_en_q[`INT_RESP])))
        else $error("response checksum fault not flagged");

    a_read_once: assert property (
        i_rd_en && hit(i_addr, `OFF_CMD_STAT)
        |=> o_rd_data == $past(cmd_q) ##1 ($past(i_rd_en) || o_rd_data == 8'h00))
        else $error("read data wrong or held too long");

    a_rd_idle_zero: assert property (
        !i_rd_en |=> o_rd_data == 8'h00)
        else $error("read data seen without a read strobe");

    a_set_wins: assert property (
        clr_req && cmd_set[`BIT_CRC] |=> cmd_q[`BIT_CRC])
        else $error("clear in the event cycle lost a checksum flag");

    a_resp_byte_flag: assert property (
        state_q == dc_flags_pkg::FS_RESP && i_rx_byte && !i_rx_sof && i_rx_byte_err && !dir_q
        |=> resp_q[`BIT_BYTE] && diag_q[`DIAG_SUM])
        else $error("response byte fault not flagged");

    a_skip_holds: assert property (
        state_q == dc_flags_pkg::FS_SKIP && !i_frame_end |=> state_q == dc_flags_pkg::FS_SKIP)
        else $error("skipped frame checked before its end");

    a_init_fault: assert property (
        state_q == dc_flags_pkg::FS_IDLE && i_rx_byte && !i_rx_sof && dir_q |=> cmd_q[`BIT_INIT])
        else $error("initialization byte without marker not flagged");

    // the line lags its status bits by exactly one cycle
    a_irq_follows: assert property (
        |(int_q & int_en_q) |=> irq_q)
        else $error("interrupt low with an enabled bit set");

    a_irq_quiet: assert property (
        !(|(int_q & int_en_q)) |=> !irq_q)
        else $error("interrupt high with no enabled bit set");

    c_cmd_crc: cover property (state_q == dc_flags_pkg::FS_CMD ##[1:20] cmd_q[`BIT_CRC]);
    c_resp_sof: cover property (state_q == dc_flags_pkg::FS_RESP ##[1:20] resp_q[`BIT_SOF]);
    c_unexp_irq: cover property (cmd_set[`BIT_UNEXP] ##[1:4] irq_q);
    c_clear_race: cover property (clr_req && cmd_set != `RST_BYTE);
    c_resp_byte: cover property (resp_set[`BIT_BYTE]);

endmodule

`default_nettype wire

/* core/dc_sticky_bits.sv */
// bank of sticky flag bits, set wins over clear
`timescale 1ns/1ps
`default_nettype none

module dc_sticky_bits #(
    parameter int W = 8
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_set,
    input  wire logic [W-1:0] i_clr,
    output logic      [W-1:0] o_bits
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always_ff @(posedge i_mclk or negedge i_resetn) begin
                if (!i_resetn) begin
                    o_bits[g] <= 1'b0;
                end else if (i_set[g]) begin
                    o_bits[g] <= 1'b1;
                end else if (i_clr[g]) begin
                    o_bits[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

/* verif/chain_neighbour.sv */
// behavioural neighbour device sending frames into the high side chain port
`timescale 1ns/1ps
`default_nettype none

module chain_neighbour (
    input  wire logic i_mclk,
    output logic      o_rx_byte,
    output logic      o_rx_sof,
    output logic      o_rx_resp,
    output logic      o_rx_init_err,
    output logic      o_rx_byte_err,
    output logic      o_frame_end,
    output logic      o_crc_ok
);
    initial begin
        o_rx_byte     <= 1'h0;
        o_rx_sof      <= 1'h0;
        o_rx_resp     <= 1'h0;
        o_rx_init_err <= 1'h0;
        o_rx_byte_err <= 1'h0;
        o_frame_end   <= 1'h0;
        o_crc_ok      <= 1'h0;
    end

    // init byte, three data bytes, then the end marker; at selects a faulty data byte
    task automatic send_frame(input logic rsp, input logic sof, input logic ierr,
                              input logic [1:0] at, input logic esof, input logic crc);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            o_rx_byte     <= 1'h1;
            o_rx_sof      <= (i == 0) ? sof : (esof && i == int'(at));
            o_rx_resp     <= rsp;
            o_rx_init_err <= (i == 0) && ierr;
            o_rx_byte_err <= (i != 0) && (i == int'(at));
        end
        @(posedge i_mclk);
        o_rx_byte     <= 1'h0;
        o_frame_end   <= 1'h1;
        o_crc_ok      <= crc;
        // unqualified lines must not look like a held byte, so flip them
        o_rx_sof      <= ~o_rx_sof;
        o_rx_byte_err <= ~o_rx_byte_err;
        @(posedge i_mclk);
        o_frame_end   <= 1'h0;
        o_crc_ok      <= ~crc;
    endtask
endmodule

`default_nettype wire

/* verif/dc_frame_error_flags_test.sv */
// self-checking bench for the chain port error flags
`timescale 1ns/1ps
`default_nettype none

module dc_frame_error_flags_test;
    typedef struct {
        logic       dir;
        logic       rsp;
        logic       sof;
        logic       ierr;
        logic [1:0] at;
        logic       esof;
        logic       crc;
        logic [7:0] cmd;
        logic [7:0] rst;
        logic [7:0] dg;
    } row_t;

    logic        i_mclk   = 1'h0;
    logic        i_resetn = 1'h0;
    logic [11:0] addr     = 12'h000;
    logic [7:0]  wdat     = 8'h00;
    logic        wr       = 1'h0;
    logic        rd       = 1'h0;
    logic [3:0]  diag     = 4'h0;
    logic [7:0]  v;
    wire logic [7:0] rdat;
    wire logic   irq, dsel, rxb, rxs, rxr, rxi, rxe, fe, crc;
    int          failures    = 0;
    int          check_count = 0;
    row_t        rows[12] = '{
        '{1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 8'h01, 8'h00, 8'h00},
        '{1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00},
        '{1'h1, 1'h0, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0, 8'h04, 8'h00, 8'h10},
        '{1'h1, 1'h0, 1'h1, 1'h0, 2'h3, 1'h1, 1'h1, 8'h08, 8'h00, 8'h00},
        '{1'h1, 1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1, 8'h20, 8'h00, 8'h00},
        '{1'h1, 1'h0, 1'h1, 1'h1, 2'h0, 1'h0, 1'h1, 8'h20, 8'h00, 8'h00},
        '{1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 1'h0, 1'h0, 8'h02, 8'h00, 8'h00},
        '{1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 8'h00, 8'h02, 8'h00},
        '{1'h0, 1'h1, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0, 8'h00, 8'h01, 8'h00},
        '{1'h0, 1'h1, 1'h1, 1'h0, 2'h1, 1'h0, 1'h1, 8'h00, 8'h04, 8'h10},
        '{1'h0, 1'h1, 1'h1, 1'h0, 2'h2, 1'h1, 1'h1, 8'h00, 8'h08, 8'h00},
        '{1'h0, 1'h1, 1'h0, 1'h0, 2'h0, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00}
    };

    dc_frame_error_flags u_dut (
        .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(addr), .i_wr_data(wdat), .i_wr_en(wr),
        .i_rd_en(rd), .o_rd_data(rdat), .i_rx_byte(rxb), .i_rx_sof(rxs), .i_rx_resp(rxr),
        .i_rx_init_err(rxi), .i_rx_byte_err(rxe), .i_frame_end(fe), .i_crc_ok(crc),
        .i_bit_diag(diag), .o_irq(irq), .o_dir_sel(dsel)
    );

    chain_neighbour u_nb (
        .i_mclk(i_mclk), .o_rx_byte(rxb), .o_rx_sof(rxs), .o_rx_resp(rxr), .o_rx_init_err(rxi),
        .o_rx_byte_err(rxe), .o_frame_end(fe), .o_crc_ok(crc)
    );

    always #20 i_mclk = ~i_mclk;

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        chk8(n, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdat <= d;
        wr   <= 1'h1;
        @(posedge i_mclk);
        wr   <= 1'h0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        rd   <= 1'h1;
        @(posedge i_mclk);
        rd   <= 1'h0;
        #1;
        d = rdat;
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk8(n, e, d);
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge i_mclk);
        i_resetn <= 1'h1;
        rd_chk("cmd_stat", 12'h784, 8'h00);
        rd_chk("resp_stat", 12'h785, 8'h00);
        rd_chk("diag", 12'h783, 8'h00);
        rd_chk("unmapped", 12'h7ff, 8'h00);
        $display("reset test done");
        foreach (rows[k]) begin
            // clear all error flags and set direction in one write
            wr_reg(12'h7a0, {6'h00, 1'h1, rows[k].dir});
            u_nb.send_frame(rows[k].rsp, rows[k].sof, rows[k].ierr, rows[k].at, rows[k].esof, rows[k].crc);
            chk1("dir_sel", rows[k].dir, dsel);
            rd_chk("cmd_stat", 12'h784, rows[k].cmd);
            rd_chk("resp_stat", 12'h785, rows[k].rst);
            rd_chk("diag", 12'h783, rows[k].dg);
            $display("row %0d done", k);
        end
        wr_reg(12'h7a0, 8'h03);
        wr_reg(12'h7a2, 8'h07);
        wr_reg(12'h7a3, 8'h01);
        u_nb.send_frame(1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0);
        repeat (3) @(posedge i_mclk);
        #1;
        chk1("irq", 1'h1, irq);
        rd_chk("int_stat", 12'h7a1, 8'h01);
        wr_reg(12'h7a2, 8'h01);
        repeat (2) @(posedge i_mclk);
        #1;
        chk1("irq", 1'h0, irq);
        wr_reg(12'h7a3, 8'h02);
        u_nb.send_frame(1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0);
        repeat (3) @(posedge i_mclk);
        #1;
        chk1("irq", 1'h0, irq);
        rd_chk("int_stat", 12'h7a1, 8'h01);
        $display("interrupt test done");
        wr_reg(12'h784, 8'hff);
        wr_reg(12'h785, 8'hff);
        rd_chk("cmd_stat", 12'h784, 8'h01);
        rd_chk("resp_stat", 12'h785, 8'h00);
        @(posedge i_mclk);
        diag <= 4'h9;
        @(posedge i_mclk);
        diag <= 4'h0;
        rd_reg(12'h783, v);
        chk8("diag_bits", 8'h19, v);
        rd_chk("int_stat", 12'h7a1, 8'h05);
        $display("read only and diag test done");
        fork
            u_nb.send_frame(1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0);
            begin
                // clear write lands on the frame end edge; the new error must survive
                repeat (4) @(posedge i_mclk);
                wr_reg(12'h7a0, 8'h03);
            end
        join
        rd_chk("cmd_stat", 12'h784, 8'h01);
        rd_chk("diag", 12'h783, 8'h00);
        rd_chk("ctrl", 12'h7a0, 8'h01);
        rd_chk("int_en", 12'h7a3, 8'h02);
        $display("clear race test done");
        @(posedge i_mclk);
        i_resetn <= 1'h0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'h1;
        rd_chk("cmd_stat", 12'h784, 8'h00);
        chk1("dir_sel", 1'h0, dsel);
        chk1("irq", 1'h0, irq);
        $display("second reset test done");
        wrap_up();
    end

    // whole run is a few hundred cycles; this leaves wide margin
    initial begin
        #(40 * 5000);
        failures++;
        wrap_up();
    end
endmodule

`default_nettype wire
